/* File: logic/ifc_pkg.sv */
// What this block does
// - product description read as 16 registers from 0xA2 to 0xB3, each a 7-bit ascii character, skipping the flag mirrors at 0xA7 and 0xAF
// - source-class code register, 0x00 unknown up to 0x09 general computer
// - mpeg bit rate in hertz over four bytes, lsb at 0xB9; only 31 bits read back, as bit 4 of 0xBC gives the field-repeat bit
// - field-repeat bit in bit 4 of 0xBC: 0 new field, 1 repeated field
// - picture type in bits 1:0 of 0xBD: 00 unknown, 01 I, 10 B, 11 P
// - 7-bit read-only new-data-flag mirrors at 0x9F, 0xA7, 0xAF and 0xB7
// - vendor name held as eight 7-bit ascii character registers from 0x99 to 0xA1, skipping the flag mirror at 0x9F
package ifc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_SPD_VERSION = 8'h98;
  localparam logic [7:0] IDX_VENDOR [8] = '{8'h99, 8'h9a, 8'h9b, 8'h9c,
                                             8'h9d, 8'h9e, 8'ha0, 8'ha1};
  localparam logic [7:0] IDX_PRODUCT [16] = '{8'ha2, 8'ha3, 8'ha4, 8'ha5,
                                              8'ha6, 8'ha8, 8'ha9, 8'haa,
                                              8'hab, 8'hac, 8'had, 8'hae,
                                              8'hb0, 8'hb1, 8'hb2, 8'hb3};
  localparam logic [7:0] IDX_FLAGS [4]    = '{8'h9f, 8'ha7, 8'haf, 8'hb7};
  localparam logic [7:0] IDX_SOURCE_CLASS = 8'hb4;
  localparam logic [7:0] IDX_MPEG_VERSION = 8'hb8;
  localparam logic [7:0] IDX_RATE [4]     = '{8'hb9, 8'hba, 8'hbb, 8'hbc};
  localparam logic [7:0] IDX_PICTURE      = 8'hbd;
  localparam logic [7:0] IDX_IRQ_STATUS   = 8'he0;
  localparam logic [7:0] IDX_IRQ_MASK     = 8'he1;

  // payload byte positions inside each packet stream
  localparam int SPD_POS_VERSION = 0;
  localparam int SPD_POS_VENDOR  = 1;
  localparam int SPD_POS_PRODUCT = 9;
  localparam int SPD_POS_CLASS   = 25;
  localparam int MPG_POS_VERSION = 0;
  localparam int MPG_POS_RATE    = 1;
  localparam int MPG_POS_MISC    = 5;

  localparam logic [4:0] SPD_LEN = 5'd26;
  localparam logic [4:0] MPG_LEN = 5'd6;
  localparam int         MAX_LEN = 26;

  localparam int FR_BIT       = 4;
  localparam int FLAG_W       = 7;
  localparam int FLAG_SPD     = 0;
  localparam int FLAG_MPG     = 1;

  localparam logic [6:0]  RST_FLAGS  = 7'h00;
  localparam logic [6:0]  RST_MASK   = 7'h00;
  localparam logic [31:0] RST_HRDATA = 32'h0000_0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;

  typedef enum logic {
    IFC_PKT_SPD  = 1'b0,
    IFC_PKT_MPEG = 1'b1
  } ifc_pkt_type;

  typedef enum logic {
    IFC_ST_IDLE    = 1'b0,
    IFC_ST_COLLECT = 1'b1
  } ifc_fsm_type;

  typedef enum logic [1:0] {
    IFC_PIC_UNKNOWN = 2'b00,
    IFC_PIC_INTRA   = 2'b01,
    IFC_PIC_BIDIR   = 2'b10,
    IFC_PIC_PRED    = 2'b11
  } ifc_picture_type;

  typedef enum logic [7:0] {
    IFC_SRC_UNKNOWN  = 8'h00,
    IFC_SRC_SETTOP   = 8'h01,
    IFC_SRC_DISC     = 8'h02,
    IFC_SRC_TAPE     = 8'h03,
    IFC_SRC_HDD      = 8'h04,
    IFC_SRC_CAMCORD  = 8'h05,
    IFC_SRC_STILLCAM = 8'h06,
    IFC_SRC_VIDDISC  = 8'h07,
    IFC_SRC_GAME     = 8'h08,
    IFC_SRC_COMPUTER = 8'h09
  } ifc_source_class_type;

endpackage : ifc_pkg

/* File: logic/ifc_regs.sv */
`timescale 1ns/1ps
module ifc_regs
  import ifc_pkg::*;
(
  // clock, reset, enable
  input  wire logic                 CLK,
  input  wire logic                 RST,
  input  wire logic                 CE,
  // ahb-lite slave
  input  wire logic                 HSEL,
  input  wire logic [31:0]          HADDR,
  input  wire logic [1:0]           HTRANS,
  input  wire logic                 HWRITE,
  input  wire logic [2:0]           HSIZE,
  input  wire logic [31:0]          HWDATA,
  input  wire logic                 HREADY,
  output logic      [31:0]          HRDATA,
  output logic                      HREADYOUT,
  output logic                      HRESP,
  // packet byte stream from receiver
  input  wire logic                 PKT_START,
  input  wire ifc_pkg::ifc_pkt_type PKT_TYPE,
  input  wire logic                 PKT_BYTE_VALID,
  input  wire logic [7:0]           PKT_BYTE,
  input  wire logic                 PKT_END,
  input  wire logic                 PKT_GOOD,
  // interrupt
  output logic                      IRQ
);
  import ifc_pkg::*;

  typedef struct packed {
    ifc_fsm_type          fsm;
    ifc_pkt_type          ptype;
    logic [4:0]           cnt;
    logic [MAX_LEN-1:0][7:0] shadow;
    logic [MAX_LEN-1:0][7:0] spd;
    logic [5:0][7:0]      mpg;
    logic [FLAG_W-1:0]    flags;
    logic [FLAG_W-1:0]    mask;
    logic                 wr_pend;
    logic [7:0]           wr_idx;
    logic [31:0]          hrdata;
    logic                 irq;
  } ifc_state_type;

  ifc_state_type st_r;
  ifc_state_type st_nxt;

  logic       addr_ok;
  logic [7:0] addr_idx;
  logic       acc_valid;

  // expected payload length per packet kind
  function automatic logic [4:0] pkt_len(input ifc_pkt_type t);
    pkt_len = (t == IFC_PKT_MPEG) ? MPG_LEN : SPD_LEN;
  endfunction : pkt_len

  // read decode over the whole map; unmapped reads zero
  function automatic logic [31:0] rd_word(input logic [7:0] idx, input ifc_state_type s);
    rd_word = 32'h0000_0000;
    if (idx == IDX_SPD_VERSION)
      rd_word = {24'h00_0000, s.spd[SPD_POS_VERSION]};
    for (int i = 0; i < 8; i++)
      if (idx == IDX_VENDOR[i])
        rd_word = {25'h000_0000, s.spd[SPD_POS_VENDOR+i][6:0]};
    for (int i = 0; i < 16; i++)
      if (idx == IDX_PRODUCT[i])
        rd_word = {25'h000_0000, s.spd[SPD_POS_PRODUCT+i][6:0]};
    for (int i = 0; i < 4; i++)
      if (idx == IDX_FLAGS[i])
        rd_word = {25'h000_0000, s.flags};
    if (idx == IDX_SOURCE_CLASS)
      rd_word = {24'h00_0000, s.spd[SPD_POS_CLASS]};
    if (idx == IDX_MPEG_VERSION)
      rd_word = {24'h00_0000, s.mpg[MPG_POS_VERSION]};
    for (int i = 0; i < 3; i++)
      if (idx == IDX_RATE[i])
        rd_word = {24'h00_0000, s.mpg[MPG_POS_RATE+i]};
    if (idx == IDX_RATE[3])
    begin
      rd_word = {24'h00_0000, s.mpg[MPG_POS_RATE+3]};
      rd_word[FR_BIT] = s.mpg[MPG_POS_MISC][FR_BIT];
    end
    if (idx == IDX_PICTURE)
      rd_word = {30'h0000_0000, s.mpg[MPG_POS_MISC][1:0]};
    if (idx == IDX_IRQ_STATUS)
      rd_word = {25'h000_0000, s.flags};
    if (idx == IDX_IRQ_MASK)
      rd_word = {25'h000_0000, s.mask};
  endfunction : rd_word

  assign addr_ok   = (HADDR[31:10] == 22'h00_0000);
  assign addr_idx  = addr_ok ? HADDR[9:2] : 8'h00;
  assign acc_valid = HSEL && HTRANS[1] && HREADY;

  always_comb
  begin
    st_nxt = st_r;
    // data phase of a write: only status and mask take it
    if (st_r.wr_pend)
    begin
      if (st_r.wr_idx == IDX_IRQ_STATUS)
        st_nxt.flags = st_r.flags & ~HWDATA[FLAG_W-1:0];
      else if (st_r.wr_idx == IDX_IRQ_MASK)
        st_nxt.mask = HWDATA[FLAG_W-1:0];
      // all packet registers drop writes
    end
    st_nxt.wr_pend = 1'b0;
    // packet collection into the shadow
    if (PKT_START)
    begin
      st_nxt.fsm   = IFC_ST_COLLECT;
      st_nxt.ptype = PKT_TYPE;
      st_nxt.cnt   = 5'd0;
    end
    else
    begin
      case (st_r.fsm)
        IFC_ST_IDLE:
        begin
          st_nxt.fsm = IFC_ST_IDLE;
        end
        IFC_ST_COLLECT:
        begin
          if (PKT_BYTE_VALID && (st_r.cnt < pkt_len(st_r.ptype)))
          begin
            st_nxt.shadow[st_r.cnt] = PKT_BYTE;
            st_nxt.cnt = st_r.cnt + 5'd1;
          end
          if (PKT_END)
          begin
            st_nxt.fsm = IFC_ST_IDLE;
            // commit only a whole, error-free packet; flag set wins over clear
            if (PKT_GOOD && (st_nxt.cnt == pkt_len(st_r.ptype)))
            begin
              if (st_r.ptype == IFC_PKT_SPD)
              begin
                st_nxt.spd = st_nxt.shadow;
                st_nxt.flags[FLAG_SPD] = 1'b1;
              end
              else
              begin
                for (int i = 0; i < 6; i++)
                  st_nxt.mpg[i] = st_nxt.shadow[i];
                st_nxt.flags[FLAG_MPG] = 1'b1;
              end
            end
          end
        end
        default:
        begin
          st_nxt.fsm = IFC_ST_IDLE;
        end
      endcase
    end
    // address phase: reads sample the post-update image
    if (acc_valid)
    begin
      if (HWRITE)
      begin
        st_nxt.wr_pend = 1'b1;
        st_nxt.wr_idx  = addr_idx;
      end
      else
        st_nxt.hrdata = rd_word(addr_idx, st_nxt);
    end
    st_nxt.irq = |(st_nxt.flags & st_nxt.mask);
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      st_r.fsm     <= IFC_ST_IDLE;
      st_r.ptype   <= IFC_PKT_SPD;
      st_r.cnt     <= 5'd0;
      st_r.shadow  <= '0;
      st_r.spd     <= '0;
      st_r.mpg     <= '0;
      st_r.flags   <= RST_FLAGS;
      st_r.mask    <= RST_MASK;
      st_r.wr_pend <= 1'b0;
      st_r.wr_idx  <= 8'h00;
      st_r.hrdata  <= RST_HRDATA;
      st_r.irq     <= 1'b0;
    end
    else if (CE)
    begin
      st_r <= st_nxt;
    end
  end

  assign HRDATA    = st_r.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign IRQ       = st_r.irq;

  // assertion helpers
  logic       rd_hit;
  logic       commit_spd;
  logic       commit_mpg;
  logic       bad_end;
  logic [7:0] sh_idx;

  assign sh_idx     = HADDR[9:2];
  assign rd_hit     = CE && acc_valid && !HWRITE && addr_ok;
  assign commit_spd = CE && !PKT_START && (st_r.fsm == IFC_ST_COLLECT) && PKT_END
                      && PKT_GOOD && !PKT_BYTE_VALID && (st_r.ptype == IFC_PKT_SPD)
                      && (st_r.cnt == SPD_LEN);
  assign commit_mpg = CE && !PKT_START && (st_r.fsm == IFC_ST_COLLECT) && PKT_END
                      && PKT_GOOD && !PKT_BYTE_VALID && (st_r.ptype == IFC_PKT_MPEG)
                      && (st_r.cnt == MPG_LEN);
  assign bad_end    = CE && !PKT_START && (st_r.fsm == IFC_ST_COLLECT) && PKT_END
                      && !PKT_GOOD;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_product_first_char: assert property (
    rd_hit && (sh_idx == IDX_PRODUCT[0])
    |=> HRDATA == {25'h000_0000, $past(st_nxt.spd[SPD_POS_PRODUCT][6:0])})
    else $error("product character one read mismatch");

  a_product_last_char: assert property (
    rd_hit && (sh_idx == IDX_PRODUCT[15])
    |=> (HRDATA[31:7] == 25'h000_0000)
        && (HRDATA[6:0] == $past(st_nxt.spd[SPD_POS_PRODUCT+15][6:0])))
    else $error("product character sixteen read mismatch");

  a_source_class_read: assert property (
    rd_hit && (sh_idx == IDX_SOURCE_CLASS)
    |=> HRDATA == {24'h00_0000, $past(st_nxt.spd[SPD_POS_CLASS])})
    else $error("source class read mismatch");

  a_rate_low_byte: assert property (
    rd_hit && (sh_idx == IDX_RATE[0])
    |=> HRDATA == {24'h00_0000, $past(st_nxt.mpg[MPG_POS_RATE])})
    else $error("rate low byte read mismatch");

  a_repeat_bit_read: assert property (
    rd_hit && (sh_idx == IDX_RATE[3])
    |=> HRDATA[FR_BIT] == $past(st_nxt.mpg[MPG_POS_MISC][FR_BIT]))
    else $error("field repeat bit read mismatch");

  a_picture_type_read: assert property (
    rd_hit && (sh_idx == IDX_PICTURE)
    |=> HRDATA == {30'h0000_0000, $past(st_nxt.mpg[MPG_POS_MISC][1:0])})
    else $error("picture type read mismatch");

  a_flag_mirror_read: assert property (
    rd_hit && ((sh_idx == IDX_FLAGS[0]) || (sh_idx == IDX_FLAGS[3]))
    |=> HRDATA == {25'h000_0000, $past(st_nxt.flags)})
    else $error("new data flag mirror mismatch");

  a_spd_commit_flag: assert property (
    commit_spd |=> st_r.flags[FLAG_SPD] ##1 (st_r.flags[FLAG_SPD] || !CE || $past(st_r.wr_pend)))
    else $error("spd new data flag not set on commit");

  a_vendor_store: assert property (
    commit_spd
    |=> st_r.spd[SPD_POS_VENDOR] == $past(st_r.shadow[SPD_POS_VENDOR]))
    else $error("vendor character not stored on commit");

  a_mpeg_commit: assert property (
    commit_mpg
    |=> (st_r.mpg[MPG_POS_RATE+3] == $past(st_r.shadow[MPG_POS_RATE+3]))
        && st_r.flags[FLAG_MPG])
    else $error("mpeg packet not committed");

  a_bad_packet_hold: assert property (
    bad_end |=> $stable(st_r.spd) && $stable(st_r.mpg))
    else $error("bad packet changed captured registers");

  a_write_no_effect: assert property (
    CE && st_r.wr_pend && (st_r.wr_idx != IDX_IRQ_STATUS) && !PKT_END
    |=> $stable(st_r.spd) && $stable(st_r.mpg))
    else $error("software write altered capture registers");

  a_irq_follows: assert property (
    CE ##1 CE |-> IRQ == |($past(st_nxt.flags) & $past(st_nxt.mask)))
    else $error("interrupt level does not follow masked status");

  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus answer not ready and okay");

  c_spd_commit: cover property (commit_spd ##[1:40] rd_hit && (sh_idx == IDX_PRODUCT[0]));
  c_mpeg_commit: cover property (commit_mpg ##1 IRQ);
  c_bad_packet: cover property (bad_end);
  c_status_clear: cover property (CE && st_r.wr_pend && (st_r.wr_idx == IDX_IRQ_STATUS)
                                  && (st_r.flags != 7'h00));

endmodule : ifc_regs

/* File: verif/test_infoframe_capture_registers.sv */
`timescale 1ns/1ps
module test_infoframe_capture_registers;
  import ifc_pkg::*;

  typedef struct {logic [7:0] idx; logic [31:0] exp;} ifc_row_type;

  logic        clk, rst, ce, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic        pkt_start, pkt_valid, pkt_end, pkt_good;
  ifc_pkt_type pkt_type;
  logic [7:0]  pkt_byte;
  logic [7:0]  pb [MAX_LEN];
  ifc_row_type rows [33];
  int          err_count, checks, cyc;

  ifc_regs dut_u (.CLK(clk), .RST(rst), .CE(ce), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .PKT_START(pkt_start),
    .PKT_TYPE(pkt_type), .PKT_BYTE_VALID(pkt_valid), .PKT_BYTE(pkt_byte),
    .PKT_END(pkt_end), .PKT_GOOD(pkt_good), .IRQ(irq));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  // one single ahb-lite transfer, waits on hready in both phases
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    // let outputs launched at that edge settle before callers look
    @(negedge clk);
  endtask : bus

  task automatic rreg(input logic [7:0] i);
    bus(1'b0, {22'h0, i, 2'b00}, 32'h0);
  endtask : rreg

  task automatic wreg(input logic [7:0] i, input logic [31:0] d);
    bus(1'b1, {22'h0, i, 2'b00}, d);
  endtask : wreg

  task automatic pkt(input ifc_pkt_type t, input int n, input logic g);
    @(posedge clk);
    pkt_start <= 1'b1;
    pkt_type <= t;
    @(posedge clk);
    pkt_start <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      pkt_valid <= 1'b1;
      pkt_byte <= pb[i];
      @(posedge clk);
    end
    pkt_valid <= 1'b0;
    pkt_byte <= ~pkt_byte;
    pkt_end <= 1'b1;
    pkt_good <= g;
    @(posedge clk);
    pkt_end <= 1'b0;
    pkt_good <= ~g;
    @(posedge clk);
  endtask : pkt

  task automatic mpeg(input logic [31:0] rate, input logic [7:0] misc, input int n);
    pb[0] = 8'h01;
    for (int i = 0; i < 4; i++)
      pb[1 + i] = rate[8 * i +: 8];
    pb[5] = misc;
    pkt(IFC_PKT_MPEG, n, 1'b1);
  endtask : mpeg

  initial
  begin
    {cyc, err_count, checks} = '0;
    {rst, ce} = 2'b11;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {pkt_start, pkt_valid, pkt_end, pkt_good, pkt_byte} = '0;
    pkt_type = IFC_PKT_SPD;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk("irq after reset", 32'h0, {31'h0, irq});
    rreg(IDX_FLAGS[0]);
    chk("flags after reset", 32'h0, rd);
    $display("reset test done");

    // good product packet, every character with bit 7 set to test masking
    pb[0] = 8'h02;
    for (int i = 0; i < 8; i++)
      pb[1 + i] = 8'he1 + 8'(i);
    for (int i = 0; i < 16; i++)
      pb[9 + i] = 8'hc1 + 8'(i);
    pb[25] = IFC_SRC_COMPUTER;
    pkt(IFC_PKT_SPD, 26, 1'b1);
    mpeg(32'ha234_5678, 8'h13, 6);
    for (int i = 0; i < 8; i++)
      rows[i] = '{IDX_VENDOR[i], 32'h61 + 32'(i)};
    for (int i = 0; i < 16; i++)
      rows[8 + i] = '{IDX_PRODUCT[i], 32'h41 + 32'(i)};
    rows[24] = '{IDX_SOURCE_CLASS, 32'h09};
    for (int i = 0; i < 4; i++)
      rows[25 + i] = '{IDX_FLAGS[i], 32'h03};
    rows[29] = '{IDX_RATE[0], 32'h78};
    rows[30] = '{IDX_RATE[1], 32'h56};
    rows[31] = '{IDX_RATE[2], 32'h34};
    rows[32] = '{IDX_MPEG_VERSION, 32'h01};
    foreach (rows[i])
    begin
      rreg(rows[i].idx);
      chk("table register", rows[i].exp, rd);
    end
    $display("table test done");

    // every picture type, field repeat follows bit 0 of the type
    for (int p = 0; p < 4; p++)
    begin
      mpeg(32'ha200_0000, {3'h0, 1'(p), 2'h0, 2'(p)}, 6);
      rreg(IDX_PICTURE);
      chk("picture type", 32'(p), rd);
      rreg(IDX_RATE[3]);
      chk("rate msb and repeat", {24'h0, 3'h5, 1'(p), 4'h2}, rd);
    end
    $display("mpeg test done");

    // interrupt: masked, unmasked, cleared bit by bit
    chk("irq masked", 32'h0, {31'h0, irq});
    wreg(IDX_IRQ_MASK, 32'h3);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    wreg(IDX_IRQ_STATUS, 32'h1);
    chk("irq one left", 32'h1, {31'h0, irq});
    wreg(IDX_IRQ_STATUS, 32'h2);
    rreg(IDX_IRQ_STATUS);
    chk("status cleared", 32'h0, rd);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("interrupt test done");

    // bad and short packets change nothing, writes to captured registers ignored
    pb[9] = 8'h7a;
    pkt(IFC_PKT_SPD, 26, 1'b0);
    mpeg(32'h0000_0011, 8'h00, 5);
    wreg(IDX_RATE[0], 32'hff);
    rreg(IDX_PRODUCT[0]);
    chk("product after bad packet", 32'h41, rd);
    rreg(IDX_RATE[0]);
    chk("rate after short packet and write", 32'h00, rd);
    rreg(IDX_FLAGS[3]);
    chk("flags after refused packets", 32'h0, rd);
    chk("irq after refused packets", 32'h0, {31'h0, irq});
    rreg(IDX_SOURCE_CLASS);
    chk("class before unmapped read", 32'h09, rd);
    bus(1'b0, 32'h0000_0400, 32'h0);
    chk("unmapped read", 32'h0, rd);
    chk("response okay", 32'h0, {31'h0, hresp});
    chk("ready", 32'h1, {31'h0, hreadyout});
    $display("refusal test done");

    // frozen clock enable drops a whole packet
    ce <= 1'b0;
    mpeg(32'h0000_0055, 8'h00, 6);
    ce <= 1'b1;
    rreg(IDX_RATE[0]);
    chk("rate after frozen packet", 32'h00, rd);
    rreg(IDX_FLAGS[1]);
    chk("flags after frozen packet", 32'h0, rd);
    $display("clock enable test done");

    // mid-run reset clears captured registers
    rreg(IDX_VENDOR[0]);
    chk("vendor before reset", 32'h61, rd);
    rst <= 1'b1;
    @(posedge clk);
    chk("hrdata in reset", 32'h0, hrdata);
    rst <= 1'b0;
    rreg(IDX_VENDOR[0]);
    chk("vendor after reset", 32'h0, rd);
    $display("second reset test done");
    end_sim();
  end

endmodule : test_infoframe_capture_registers
